/* File: logic/sps_regs.svh */
// Timing and geometry constants of the split-port burst SRAM link
`ifndef SPS_REGS_SVH
`define SPS_REGS_SVH

`define SPS_CLK_NS 4
`define SPS_BURST_LEN 4
`define SPS_WORD_W 18
`define SPS_LANES 2
`define SPS_ADDR_W 20
`define SPS_DLL_STRETCH_NS 30
`define SPS_DLL_STRETCH_CYC ((`SPS_DLL_STRETCH_NS + `SPS_CLK_NS) / `SPS_CLK_NS)
`define SPS_DLL_CNT_W 4
`define SPS_ZQ_PERIOD_CYC 1024
`define SPS_ZQ_CNT_W 10

`endif

/* File: logic/sps_pkg.sv */
// Types shared by both ends of the split-port burst SRAM link
package sps_pkg;

    typedef enum logic [1:0] {
        sps_op_idle,
        sps_op_read,
        sps_op_write
    } sps_op_type;

endpackage : sps_pkg

/* File: logic/sps_if.sv */
// Link interface between the burst SRAM device end and its controller end
`timescale 1ns/1ns
`include "sps_regs.svh"

interface sps_if #(
    parameter int ADDR_W = `SPS_ADDR_W,
    parameter int WORD_W = `SPS_WORD_W,
    parameter int LANES = `SPS_LANES
);
    logic k_clk;
    logic k_clk_n;
    logic c_clk;
    logic c_clk_n;
    logic read_port_select_n;
    logic write_port_select_n;
    logic [ADDR_W-1:0] addr;
    logic [WORD_W-1:0] d;
    logic [LANES-1:0] byte_write_select_n;
    logic [WORD_W-1:0] q;
    logic q_oe;
    logic echo_clock;
    logic echo_clock_n;
    // Read data as the controller sees it; held low while the device does not drive it
    wire [WORD_W-1:0] q_pin;

    assign q_pin = q_oe ? q : {WORD_W{1'b0}};

    modport device (
        input k_clk, k_clk_n, c_clk, c_clk_n,
        input read_port_select_n, write_port_select_n, addr, d, byte_write_select_n,
        output q, q_oe, echo_clock, echo_clock_n
    );

    modport ctrl (
        output k_clk, k_clk_n, c_clk, c_clk_n,
        output read_port_select_n, write_port_select_n, addr, d, byte_write_select_n,
        input q_pin, q_oe, echo_clock, echo_clock_n
    );
endinterface : sps_if

/* File: logic/sps_array.sv */
// Storage array of the burst SRAM with per-lane write masking
`timescale 1ns/1ns

module sps_array #(
    parameter int AW = 22,
    parameter int WORD_W = 18,
    parameter int LANES = 2
) (
    // Clock
    input wire logic core_clk,
    // Write port
    input wire logic wr_en,
    input wire logic [AW-1:0] wr_addr,
    input wire logic [WORD_W-1:0] wr_data,
    input wire logic [LANES-1:0] wr_lane_n,
    // Read port
    input wire logic [AW-1:0] rd_addr,
    output logic [WORD_W-1:0] rd_data
);
    if (WORD_W % LANES != 0 || AW < 1) begin : g_bad_geometry
        $error("sps_array: word width or address width not supported");
    end

    localparam int LANE_W = WORD_W / LANES;

    logic [WORD_W-1:0] mem [0:(1<<AW)-1];

    // Active-low lane selects widened to a bit mask
    function automatic logic [WORD_W-1:0] lane_mask(input logic [LANES-1:0] lane_n);
        logic [WORD_W-1:0] m;
        m = '0;
        for (int i = 0; i < LANES; i++) begin
            m[i*LANE_W +: LANE_W] = {LANE_W{~lane_n[i]}};
        end
        return m;
    endfunction : lane_mask

    wire [WORD_W-1:0] wr_keep = lane_mask(wr_lane_n);

    assign rd_data = mem[rd_addr];

    always_ff @(posedge core_clk) begin
        if (wr_en) begin
            mem[wr_addr] <= (mem[wr_addr] & ~wr_keep) | (wr_data & wr_keep);
        end
    end
endmodule : sps_array

/* File: logic/sps_device.sv */
// Device end of the split-port burst SRAM link: port logic, array and housekeeping
//
// Contract
// - Read select low at K rise latches address
// - Burst words out lowest first after next K
// - Every read runs four words over two cycles
// - Read on consecutive K rises: second one dropped
// - Deselected read port tri-states after pending bursts
// - Write select low at K rise starts write
// - Four write words collected, committed at address
// - Write on consecutive K rises: second one dropped
// - Deselected write port ignores inputs after burst
// - Byte selects sampled per word gate lanes
// - Output clocks high at power-on: single-clock mode
// - Read after write returns newest data
// - Both selects: arbitration by previous operation
// - Controller starts one transaction per cycle
// - Selects sampled only on K rises
// - Ports independent; pending work always completes
// - Control inputs registered on input clocks
// - Impedance recalibrated every 1024 cycles
// - Free-running echo clocks follow output clocks
// - DLL off when disabled, reset when stretched
// - Power up deselected with outputs high-impedance
`timescale 1ns/1ns
`include "sps_regs.svh"

module sps_device #(
    parameter int ADDR_W = `SPS_ADDR_W,
    parameter int WORD_W = `SPS_WORD_W,
    parameter int LANES = `SPS_LANES
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_b,
    // Link to the controller
    sps_if.device link,
    // Board strap
    input wire logic dll_disable_n,
    // Status
    output logic single_clock_mode,
    output logic dll_active,
    output logic dll_reset,
    output logic impedance_update
);
    // ************************************************************
    // Geometry
    // ************************************************************
    if (WORD_W % LANES != 0 || ADDR_W < 1 || ADDR_W > `SPS_ADDR_W) begin : g_bad_geometry
        $error("sps_device: word width or address width not supported");
    end

    localparam int IDX_W = $clog2(`SPS_BURST_LEN);
    localparam logic [IDX_W-1:0] LAST_IDX = IDX_W'(`SPS_BURST_LEN - 1);
    localparam logic [`SPS_DLL_CNT_W-1:0] STRETCH_CYC = `SPS_DLL_CNT_W'(`SPS_DLL_STRETCH_CYC);
    localparam logic [`SPS_ZQ_CNT_W-1:0] ZQ_LAST = `SPS_ZQ_CNT_W'(`SPS_ZQ_PERIOD_CYC - 1);

    // ************************************************************
    // Port select sampling and arbitration
    // ************************************************************
    logic k_prev_r;
    sps_pkg::sps_op_type prev_op_r;
    sps_pkg::sps_op_type prev_op_nxt;

    // A K rise is the first core cycle with the input clock high
    wire k_rise = link.k_clk & ~k_prev_r;
    wire rd_req = k_rise & ~link.read_port_select_n;
    wire wr_req = k_rise & ~link.write_port_select_n;
    // Back-to-back starts of the same kind are dropped; a tie left after that goes to the read
    wire rd_start = rd_req & (prev_op_r != sps_pkg::sps_op_read);
    wire wr_start = wr_req & (prev_op_r != sps_pkg::sps_op_write) & ~rd_start;

    always_comb begin
        prev_op_nxt = prev_op_r;
        if (k_rise) begin
            if (rd_start) begin
                prev_op_nxt = sps_pkg::sps_op_read;
            end else if (wr_start) begin
                prev_op_nxt = sps_pkg::sps_op_write;
            end else begin
                prev_op_nxt = sps_pkg::sps_op_idle;
            end
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            k_prev_r <= 1'b1;
            prev_op_r <= sps_pkg::sps_op_idle;
        end else begin
            k_prev_r <= link.k_clk;
            prev_op_r <= prev_op_nxt;
        end
    end

    // ************************************************************
    // Array
    // ************************************************************
    logic [ADDR_W-1:0] rd_addr_r;
    logic rd_go_r;
    logic rd_busy_r;
    logic [IDX_W-1:0] rd_idx_r;
    logic [ADDR_W-1:0] wr_addr_r;
    logic wr_go_r;
    logic [ADDR_W-1:0] wr_row_r;
    logic wr_busy_r;
    logic [IDX_W-1:0] wr_idx_r;
    logic [WORD_W-1:0] rd_word;
    wire [IDX_W-1:0] rd_sel = rd_go_r ? {IDX_W{1'b0}} : rd_idx_r;
    // Each write word lands one edge before a following read fetches it,
    // so a read right after a write to the same row sees the new data.
    sps_array #(
        .AW(ADDR_W + IDX_W),
        .WORD_W(WORD_W),
        .LANES(LANES)
    ) u_array (
        .core_clk(core_clk),
        .wr_en(wr_busy_r),
        .wr_addr({wr_row_r, wr_idx_r}),
        .wr_data(link.d),
        .wr_lane_n(link.byte_write_select_n),
        .rd_addr({rd_addr_r, rd_sel}),
        .rd_data(rd_word)
    );

    // ************************************************************
    // Read port
    // ************************************************************
    logic [WORD_W-1:0] q_r;
    logic q_oe_r;

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            rd_go_r <= 1'b0;
            rd_addr_r <= '0;
        end else begin
            rd_go_r <= rd_start;
            if (rd_start) begin
                rd_addr_r <= link.addr;
            end
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            q_r <= '0;
            q_oe_r <= 1'b0;
            rd_busy_r <= 1'b0;
            rd_idx_r <= '0;
        end else if (rd_go_r) begin
            q_r <= rd_word;
            q_oe_r <= 1'b1;
            rd_busy_r <= 1'b1;
            rd_idx_r <= IDX_W'(1);
        end else if (rd_busy_r) begin
            q_r <= rd_word;
            rd_idx_r <= rd_idx_r + 1'b1;
            rd_busy_r <= rd_idx_r != LAST_IDX;
        end else begin
            q_oe_r <= 1'b0;
        end
    end

    // ************************************************************
    // Write port
    // ************************************************************
    // The row is copied out of the address register so a write started
    // two cycles later can load a new address while words still arrive.
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            wr_go_r <= 1'b0;
            wr_addr_r <= '0;
        end else begin
            wr_go_r <= wr_start;
            if (wr_start) begin
                wr_addr_r <= link.addr;
            end
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            wr_row_r <= '0;
            wr_busy_r <= 1'b0;
            wr_idx_r <= '0;
        end else if (wr_go_r) begin
            wr_row_r <= wr_addr_r;
            wr_busy_r <= 1'b1;
            wr_idx_r <= '0;
        end else if (wr_busy_r) begin
            wr_idx_r <= wr_idx_r + 1'b1;
            wr_busy_r <= wr_idx_r != LAST_IDX;
        end
    end

    // ************************************************************
    // Strap, echo clocks
    // ************************************************************
    logic strap_done_r;
    logic single_r;
    logic echo_r;
    logic echo_n_r;

    // Caught once, on the first edge after reset release, then frozen
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            strap_done_r <= 1'b0;
            single_r <= 1'b0;
        end else if (!strap_done_r) begin
            strap_done_r <= 1'b1;
            single_r <= link.c_clk & link.c_clk_n;
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            echo_r <= 1'b0;
            echo_n_r <= 1'b1;
        end else begin
            echo_r <= single_r ? link.k_clk : link.c_clk;
            echo_n_r <= single_r ? link.k_clk_n : link.c_clk_n;
        end
    end

    // ************************************************************
    // DLL supervision and impedance update
    // ************************************************************
    logic [`SPS_DLL_CNT_W-1:0] k_gap_r;
    logic dll_active_r;
    logic dll_reset_r;
    logic [`SPS_ZQ_CNT_W-1:0] zq_cnt_r;
    logic zq_upd_r;

    wire gap_hit = ~k_rise & (k_gap_r == STRETCH_CYC - 1'b1);
    // Saturates so a stopped clock gives one reset pulse, not a stream
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            k_gap_r <= '0;
            dll_reset_r <= 1'b0;
            dll_active_r <= 1'b0;
        end else begin
            if (k_rise) begin
                k_gap_r <= '0;
            end else if (k_gap_r != STRETCH_CYC) begin
                k_gap_r <= k_gap_r + 1'b1;
            end
            dll_reset_r <= gap_hit;
            dll_active_r <= dll_disable_n & ~gap_hit & (k_gap_r != STRETCH_CYC);
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            zq_cnt_r <= '0;
            zq_upd_r <= 1'b0;
        end else begin
            zq_cnt_r <= zq_cnt_r + 1'b1;
            zq_upd_r <= zq_cnt_r == ZQ_LAST;
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    assign link.q = q_r;
    assign link.q_oe = q_oe_r;
    assign link.echo_clock = echo_r;
    assign link.echo_clock_n = echo_n_r;
    assign single_clock_mode = single_r;
    assign dll_active = dll_active_r;
    assign dll_reset = dll_reset_r;
    assign impedance_update = zq_upd_r;
endmodule : sps_device

/* File: logic/sps_ctrl.sv */
// Controller end of the split-port burst SRAM link
`timescale 1ns/1ns
`include "sps_regs.svh"

module sps_ctrl #(
    parameter int ADDR_W = `SPS_ADDR_W,
    parameter int WORD_W = `SPS_WORD_W,
    parameter int LANES = `SPS_LANES,
    parameter bit SINGLE_CLOCK = 1'b0
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_b,
    // Link to the device
    sps_if.ctrl link,
    // User request
    input wire logic req_valid,
    input wire logic req_write,
    input wire logic [ADDR_W-1:0] req_addr,
    input wire logic [`SPS_BURST_LEN*WORD_W-1:0] req_wdata,
    input wire logic [`SPS_BURST_LEN*LANES-1:0] req_wmask_n,
    // User answer
    output logic req_taken,
    output logic rd_valid,
    output logic [`SPS_BURST_LEN*WORD_W-1:0] rd_data
);
    // ************************************************************
    // Geometry
    // ************************************************************
    if (WORD_W % LANES != 0 || ADDR_W < 1) begin : g_bad_geometry
        $error("sps_ctrl: word width or address width not supported");
    end

    localparam int BW = `SPS_BURST_LEN * WORD_W;
    localparam int MW = `SPS_BURST_LEN * LANES;
    localparam int IDX_W = $clog2(`SPS_BURST_LEN);
    localparam logic [IDX_W-1:0] LAST_IDX = IDX_W'(`SPS_BURST_LEN - 1);

    // ************************************************************
    // Clock divider and launch
    // ************************************************************
    logic k_r;
    logic k_n_r;
    logic c_r;
    logic c_n_r;
    logic rps_r;
    logic wps_r;
    logic [ADDR_W-1:0] addr_r;
    logic taken_r;
    sps_pkg::sps_op_type last_op_r;

    // Selects go low only on the edge that opens a K-high cycle and return high on the next edge
    wire launch_edge = ~k_r;
    wire go_rd = launch_edge & req_valid & ~req_write & (last_op_r != sps_pkg::sps_op_read);
    wire go_wr = launch_edge & req_valid & req_write & (last_op_r != sps_pkg::sps_op_write);

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            k_r <= 1'b0;
            k_n_r <= 1'b1;
            c_r <= SINGLE_CLOCK;
            c_n_r <= 1'b1;
        end else begin
            k_r <= ~k_r;
            k_n_r <= k_r;
            c_r <= SINGLE_CLOCK | ~k_r;
            c_n_r <= SINGLE_CLOCK | k_r;
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            rps_r <= 1'b1;
            wps_r <= 1'b1;
            addr_r <= '0;
            taken_r <= 1'b0;
            last_op_r <= sps_pkg::sps_op_idle;
        end else begin
            rps_r <= ~go_rd;
            wps_r <= ~go_wr;
            taken_r <= go_rd | go_wr;
            if (go_rd | go_wr) begin
                addr_r <= req_addr;
            end
            if (launch_edge) begin
                last_op_r <= go_rd ? sps_pkg::sps_op_read
                           : (go_wr ? sps_pkg::sps_op_write : sps_pkg::sps_op_idle);
            end
        end
    end

    // ************************************************************
    // Write data
    // ************************************************************
    logic [BW-1:0] wbuf_r;
    logic [MW-1:0] wmbuf_r;
    logic arm1_r;
    logic arm2_r;
    logic [BW-1:0] wsh_r;
    logic [MW-1:0] wmsh_r;
    logic [IDX_W-1:0] wcnt_r;
    logic [WORD_W-1:0] d_r;
    logic [LANES-1:0] bws_r;

    // Shift copy frees the buffer for a write launched two cycles later
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            wbuf_r <= '0;
            wmbuf_r <= '1;
            arm1_r <= 1'b0;
            arm2_r <= 1'b0;
        end else begin
            arm1_r <= go_wr;
            arm2_r <= arm1_r;
            if (go_wr) begin
                wbuf_r <= req_wdata;
                wmbuf_r <= req_wmask_n;
            end
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            wsh_r <= '0;
            wmsh_r <= '1;
            wcnt_r <= '0;
            d_r <= '0;
            bws_r <= '1;
        end else if (arm2_r) begin
            d_r <= wbuf_r[WORD_W-1:0];
            bws_r <= wmbuf_r[LANES-1:0];
            wsh_r <= wbuf_r >> WORD_W;
            wmsh_r <= wmbuf_r >> LANES;
            wcnt_r <= LAST_IDX;
        end else if (wcnt_r != '0) begin
            d_r <= wsh_r[WORD_W-1:0];
            bws_r <= wmsh_r[LANES-1:0];
            wsh_r <= wsh_r >> WORD_W;
            wmsh_r <= wmsh_r >> LANES;
            wcnt_r <= wcnt_r - 1'b1;
        end else begin
            bws_r <= '1;
        end
    end

    // ************************************************************
    // Read capture
    // ************************************************************
    logic [BW-1:0] rsh_r;
    logic [IDX_W-1:0] rcnt_r;
    logic rd_valid_r;
    logic [BW-1:0] rd_data_r;

    wire [BW-1:0] rsh_nxt = {link.q_pin, rsh_r[BW-1:WORD_W]};
    wire rd_last = link.q_oe & (rcnt_r == LAST_IDX);

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            rsh_r <= '0;
            rcnt_r <= '0;
            rd_valid_r <= 1'b0;
            rd_data_r <= '0;
        end else begin
            rd_valid_r <= rd_last;
            if (link.q_oe) begin
                rsh_r <= rsh_nxt;
                rcnt_r <= rcnt_r + 1'b1;
            end
            if (rd_last) begin
                rd_data_r <= rsh_nxt;
            end
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    assign link.k_clk = k_r;
    assign link.k_clk_n = k_n_r;
    assign link.c_clk = c_r;
    assign link.c_clk_n = c_n_r;
    assign link.read_port_select_n = rps_r;
    assign link.write_port_select_n = wps_r;
    assign link.addr = addr_r;
    assign link.d = d_r;
    assign link.byte_write_select_n = bws_r;
    assign req_taken = taken_r;
    assign rd_valid = rd_valid_r;
    assign rd_data = rd_data_r;
endmodule : sps_ctrl

/* File: dv/sps_link_monitor.sv */
// Concurrent checks on the split-port burst SRAM link
`timescale 1ns/1ns

module sps_link_monitor #(
    parameter int LANES = 2
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_b,
    // Link signals
    input wire logic k_clk,
    input wire logic c_clk,
    input wire logic c_clk_n,
    input wire logic echo_clock,
    input wire logic echo_clock_n,
    input wire logic read_port_select_n,
    input wire logic write_port_select_n,
    input wire logic [LANES-1:0] byte_write_select_n,
    input wire logic q_oe
);
    // ****************
    // Start tracking
    // ****************
    logic k_prev_r;
    logic last_rd_r;
    logic last_wr_r;
    logic sgl_r;
    logic [1:0] up_r;
    logic [4:0] rd_sr_r;
    logic [4:0] wr_sr_r;
    // Refused starts stay out, so the windows open only for bursts that really run
    wire k_rise = k_clk & ~k_prev_r;
    wire rd_go = k_rise & ~read_port_select_n & ~last_rd_r;
    wire wr_go = k_rise & ~write_port_select_n & ~last_wr_r & ~rd_go;
    wire echo_src = sgl_r ? k_clk : c_clk;

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            k_prev_r <= 1'b0;
            last_rd_r <= 1'b0;
            last_wr_r <= 1'b0;
            sgl_r <= 1'b0;
            up_r <= 2'h0;
            rd_sr_r <= 5'h00;
            wr_sr_r <= 5'h00;
        end else begin
            k_prev_r <= k_clk;
            up_r <= up_r + {1'b0, ~&up_r};
            if (up_r == 2'h0) begin
                sgl_r <= c_clk & c_clk_n;
            end
            rd_sr_r <= {rd_sr_r[3:0], rd_go};
            wr_sr_r <= {wr_sr_r[3:0], wr_go};
            if (k_rise) begin
                last_rd_r <= rd_go;
                last_wr_r <= wr_go;
            end
        end
    end

    default clocking mon_cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_b);

    sequence rd_burst_s;
        q_oe [*4];
    endsequence

    read_burst_a: assert property (rd_go |-> ##2 rd_burst_s)
        else $error("read burst short");
    read_window_a: assert property (q_oe == |rd_sr_r[4:1])
        else $error("read data driven outside burst");
    write_lanes_a: assert property (byte_write_select_n != {LANES{1'b1}} |-> |wr_sr_r[4:1])
        else $error("byte selects outside write burst");
    read_spacing_a: assert property (k_rise && !read_port_select_n |-> !last_rd_r)
        else $error("reads on consecutive rises");
    write_spacing_a: assert property (k_rise && !write_port_select_n |-> !last_wr_r)
        else $error("writes on consecutive rises");
    single_start_a: assert property (k_rise |-> read_port_select_n || write_port_select_n)
        else $error("two starts at one rise");
    select_phase_a: assert property (!read_port_select_n || !write_port_select_n |-> k_rise)
        else $error("select low off a rise");
    echo_track_a: assert property (up_r[1] |-> echo_clock == $past(echo_src) && echo_clock_n != echo_clock)
        else $error("echo clock off its source");
endmodule : sps_link_monitor

/* File: dv/tb_top.sv */
// Bench joining the controller and device ends of the burst SRAM link
`timescale 1ns/1ns
`include "sps_regs.svh"

module tb_top;
    localparam int DW = `SPS_BURST_LEN * `SPS_WORD_W;
    localparam logic [DW-1:0] DA = 72'h123456789ABCDEF012;
    localparam logic [DW-1:0] DB = 72'hFEDCBA9876543210ED;
    logic core_clk = 1'b0;
    logic rst_b = 1'b0;
    logic req_valid = 1'b0;
    logic req_write = 1'b0;
    logic [5:0] req_addr = 6'h00;
    logic [DW-1:0] req_wdata = '0;
    logic [7:0] req_wmask_n = 8'hFF;
    logic dll_disable_n = 1'b1;
    logic req_taken;
    logic rd_valid;
    logic single_clock_mode;
    logic dll_active;
    logic impedance_update;
    logic dll_reset;
    logic [DW-1:0] rd_data;
    int num_errors = 0;
    int checks_done = 0;
    int cyc = 0;
    int lat;

    // ****************
    // Both ends
    // ****************
    sps_if #(.ADDR_W(6)) u_sps_if ();
    sps_ctrl #(.ADDR_W(6)) u_sps_ctrl (.core_clk(core_clk), .rst_b(rst_b), .link(u_sps_if.ctrl),
        .req_valid(req_valid), .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata),
        .req_wmask_n(req_wmask_n), .req_taken(req_taken), .rd_valid(rd_valid), .rd_data(rd_data));
    sps_device #(.ADDR_W(6)) u_sps_device (.core_clk(core_clk), .rst_b(rst_b), .link(u_sps_if.device),
        .dll_disable_n(dll_disable_n), .single_clock_mode(single_clock_mode), .dll_active(dll_active),
        .dll_reset(dll_reset), .impedance_update(impedance_update));
    sps_link_monitor u_sps_link_monitor (.core_clk(core_clk), .rst_b(rst_b), .k_clk(u_sps_if.k_clk),
        .c_clk(u_sps_if.c_clk), .c_clk_n(u_sps_if.c_clk_n), .echo_clock(u_sps_if.echo_clock),
        .echo_clock_n(u_sps_if.echo_clock_n), .read_port_select_n(u_sps_if.read_port_select_n),
        .write_port_select_n(u_sps_if.write_port_select_n),
        .byte_write_select_n(u_sps_if.byte_write_select_n), .q_oe(u_sps_if.q_oe));

    always #2 core_clk = ~core_clk;

    task automatic complete_run();
        $display("errors %0d checks %0d", num_errors, checks_done);
        if (num_errors == 0 && checks_done > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : complete_run

    // Backstop at cycle 5000; each handshake wait below already gives up after 20 cycles
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            num_errors = num_errors + 1;
            complete_run();
        end
    end

    task automatic check(input string name, input logic [DW-1:0] exp, input logic [DW-1:0] got);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask : check

    // Lane i of the burst is bits [9i+8:9i]; a high select keeps the old byte
    function automatic logic [DW-1:0] merge(input logic [DW-1:0] o, input logic [DW-1:0] n,
        input logic [7:0] m);
        merge = o;
        for (int i = 0; i < 8; i++) begin
            if (!m[i]) merge[9*i +: 9] = n[9*i +: 9];
        end
    endfunction : merge

    // Holds the request until taken; the caller changes it at the returning edge
    task automatic issue(input logic wr, input logic [5:0] a, input logic [DW-1:0] wd, input logic [7:0] m);
        req_valid <= 1'b1;
        req_write <= wr;
        req_addr <= a;
        req_wdata <= wd;
        req_wmask_n <= m;
        lat = 0;
        do begin
            @(posedge core_clk);
            #1;
            lat++;
        end while (req_taken !== 1'b1 && lat < 20);
        @(posedge core_clk);
    endtask : issue

    task automatic read_back(input logic [DW-1:0] exp);
        int n;
        n = 0;
        do begin
            @(posedge core_clk);
            #1;
            n++;
        end while (rd_valid !== 1'b1 && n < 20);
        check("rd_data", exp, rd_data);
    endtask : read_back

    task automatic t_power_up();
        #1;
        check("q_oe", 1'h0, u_sps_if.q_oe);
        check("single_clock_mode", 1'h0, single_clock_mode);
        @(posedge core_clk);
    endtask : t_power_up

    task automatic t_write_read();
        issue(1'b1, 6'h05, DA, 8'h00);
        req_valid <= 1'b0;
        repeat (8) @(posedge core_clk);
        issue(1'b0, 6'h05, '0, 8'hFF);
        req_valid <= 1'b0;
        read_back(DA);
        check("q_oe released", 1'h0, u_sps_if.q_oe);
        @(posedge core_clk);
    endtask : t_write_read

    task automatic t_lanes();
        issue(1'b1, 6'h09, DA, 8'h00);
        issue(1'b1, 6'h09, DB, 8'h1E);
        check("write spacing", 3, lat);
        issue(1'b0, 6'h09, '0, 8'hFF);
        check("alternate start", 1, lat);
        req_valid <= 1'b0;
        read_back(merge(DA, DB, 8'h1E));
        @(posedge core_clk);
    endtask : t_lanes

    task automatic t_reads();
        issue(1'b0, 6'h09, '0, 8'hFF);
        issue(1'b0, 6'h05, '0, 8'hFF);
        check("read spacing", 3, lat);
        req_valid <= 1'b0;
        read_back(merge(DA, DB, 8'h1E));
        @(posedge core_clk);
        read_back(DA);
        @(posedge core_clk);
    endtask : t_reads

    task automatic t_dll();
        dll_disable_n <= 1'b0;
        repeat (4) @(posedge core_clk);
        #1;
        check("dll_active off", 1'h0, dll_active);
        @(posedge core_clk);
        dll_disable_n <= 1'b1;
        repeat (4) @(posedge core_clk);
        #1;
        check("dll_active on", 1'h1, dll_active);
        check("dll_reset", 1'h0, dll_reset);
        @(posedge core_clk);
    endtask : t_dll

    task automatic t_impedance();
        int n;
        n = 0;
        #1;
        while (impedance_update !== 1'b1 && n < 1100) begin
            @(posedge core_clk);
            #1;
            n++;
        end
        n = 0;
        do begin
            @(posedge core_clk);
            #1;
            n++;
        end while (impedance_update !== 1'b1 && n < 1100);
        check("impedance period", 1024, n);
    endtask : t_impedance

    initial begin
        repeat (6) @(posedge core_clk);
        rst_b <= 1'b1;
        @(posedge core_clk);
        t_power_up();
        t_write_read();
        t_lanes();
        t_reads();
        t_dll();
        t_impedance();
        complete_run();
    end
endmodule : tb_top
